// ===== rtl/sarm_cfg.svh
// constants for the status, alarm and analog output command unit
// Function
// (RL1) clear-status wipes status and event flags, cancels waits
// (RL2) event enable loaded from weighted sum
// (RL3) weighted sums are integers 0 to 255
// (RL4) event flag bit map: OPC,QYE,DDE,EXE,CME,PON
// (RL5) event enable query returns weighted sum
// (RL6) identity query returns four fields
// (RL7) operation-complete flag set after pending work ends
// (RL8) completion query answers 1 after pending work
// (RL9) reset command restores power-up configuration
// (RL10) status byte bit map as listed
// (RL11) status query reports byte without clearing
// (RL12) service enable loaded from sum, queryable
// (RL13) summary bit follows enabled event flags
// (RL14) service request follows enabled status bits
// (RL15) power-up self-test result answered 0 or 1
// (RL16) per-input alarm configuration for eight inputs
// (RL17) high alarm with deadband release
// (RL18) low alarm with deadband release
// (RL19) latched alarm stays after condition clears
// (RL20) latched alarm clear only where condition gone
// (RL21) alarm state query returns high then low
// (RL22) beeper command sets, query returns setting
// (RL23) analog output polarity, mode, input, source stored
// (RL24) tracking spans full scale between limits
// (RL25) manual mode drives stored manual value
`ifndef SARM_CFG_SVH
`define SARM_CFG_SVH

`define SARM_EVT_OPC 0
`define SARM_EVT_QYE 2
`define SARM_EVT_DDE 3
`define SARM_EVT_EXE 4
`define SARM_EVT_CME 5
`define SARM_EVT_PON 7
`define SARM_EVT_RESET 8'h80

`define SARM_STS_NEW 0
`define SARM_STS_OVL 2
`define SARM_STS_ALM 3
`define SARM_STS_ERR 4
`define SARM_STS_ESB 5
`define SARM_STS_SRQ 6
`define SARM_STS_LOG 7

`define SARM_ENABLE_RESET 8'h00
`define SARM_BEEPER_RESET 1'h0
`define SARM_INPUTS 8
`define SARM_OUTPUTS 2
`define SARM_IDN_BEATS 2'h3
`define SARM_ALST_BEATS 2'h1
`define SARM_MODE_OFF 2'h0
`define SARM_MODE_TRACK 2'h1
`define SARM_MODE_MANUAL 2'h2
`define SARM_SCALE_UNI 64'sh186A0
`define SARM_SCALE_BI 64'sh30D40
`define SARM_SRC_FIRST 3'h1

`endif

// ===== rtl/sarm_pkg.sv
// types for the status, alarm and analog output command unit
package sarm_pkg;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_CLEAR_STATUS = 5'h01,
    OP_EVT_EN_WR = 5'h02,
    OP_EVT_EN_RD = 5'h03,
    OP_EVT_RD = 5'h04,
    OP_IDENT_RD = 5'h05,
    OP_OPC = 5'h06,
    OP_OPC_RD = 5'h07,
    OP_RESET = 5'h08,
    OP_SVC_EN_WR = 5'h09,
    OP_SVC_EN_RD = 5'h0A,
    OP_STATUS_RD = 5'h0B,
    OP_TEST_RD = 5'h0C,
    OP_WAIT = 5'h0D,
    OP_ALARM_WR = 5'h0E,
    OP_ALARM_STATE_QUERY = 5'h0F,
    OP_BEEPER_CMD = 5'h10,
    OP_BEEPER_RD = 5'h11,
    OP_LATCHED_ALARM_CLEAR_CMD = 5'h12,
    OP_ANALOG_WR = 5'h13
  } sarm_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MULTI = 3'b010,
    ST_OPC_WAIT = 3'b100
  } sarm_state_type;

  typedef logic signed [31:0] sarm_value_type;
  typedef sarm_value_type [3:0] sarm_reading_type;
  typedef sarm_reading_type [7:0] sarm_bank_type;

  typedef struct packed {
    logic check;
    logic [2:0] source;
    sarm_value_type high;
    sarm_value_type low;
    sarm_value_type band;
    logic latch;
  } sarm_alarm_cfg_type;

  typedef struct packed {
    logic bipolar;
    logic [1:0] mode;
    logic [3:0] inputSel;
    logic [2:0] source;
    sarm_value_type high;
    sarm_value_type low;
    sarm_value_type manual;
  } sarm_analog_cfg_type;

  typedef struct packed {
    sarm_op_type op;
    logic [2:0] sel;
    logic [7:0] arg;
    sarm_alarm_cfg_type alarm;
    sarm_analog_cfg_type analog;
  } sarm_cmd_type;

  typedef struct packed {
    logic [1:0] field;
    logic last;
    logic [31:0] value;
  } sarm_rsp_type;

  typedef struct packed {
    logic newReading;
    logic overload;
    logic error;
    logic logDone;
    logic queryErr;
    logic devErr;
    logic execErr;
  } sarm_event_type;

endpackage

// ===== rtl/sarm_unit.sv
// status byte, event flags, alarms, beeper and analog outputs
`timescale 1ns/100ps
`include "sarm_cfg.svh"

module sarm_unit import sarm_pkg::*; #(
  parameter logic [31:0] MAKER_CODE = 32'h00000A01,   // arbitrary value
  parameter logic [31:0] MODEL_CODE = 32'h00000B02,   // arbitrary value
  parameter logic [31:0] SERIAL_CODE = 32'h00000C03,  // arbitrary value
  parameter logic [31:0] FIRMWARE_DATE = 32'h00000D04 // arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire sarm_cmd_type cmd,
  output logic cmdReady,
  output logic rspValid,
  output sarm_rsp_type rsp,
  input wire sarm_event_type events,
  input wire logic opBusy,
  input wire logic selfTestDone,
  input wire logic selfTestFail,
  input wire sarm_bank_type readings,
  output logic [7:0] alarmHigh,
  output logic [7:0] alarmLow,
  output logic beeperOn,
  output logic beepOut,
  output sarm_value_type [1:0] analogLevel,
  output logic [7:0] eventFlags,
  output logic [7:0] statusByte,
  output logic serviceRequest
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic isOp(logic taken, sarm_op_type got, sarm_op_type want);
    isOp = taken && (got == want);
  endfunction

  // out-of-range input or source falls back to the first one
  function automatic sarm_value_type pickSource(sarm_bank_type r, logic [3:0] inp, logic [2:0] src);
    logic [2:0] i;
    logic [1:0] s;
    i = (inp >= 4'h1 && inp <= 4'h8) ? 3'(inp - 4'h1) : 3'h0;
    s = (src >= 3'h1 && src <= 3'h4) ? 2'(src - `SARM_SRC_FIRST) : 2'h0;
    pickSource = r[i][s];
  endfunction

  function automatic sarm_value_type trackLevel(sarm_value_type v, sarm_value_type lo,
                                                sarm_value_type hi, logic bip);
    logic signed [63:0] span;
    logic signed [63:0] num;
    logic signed [63:0] q;
    logic signed [63:0] floor;
    // wide math so the scaled product cannot overflow
    span = 64'(hi) - 64'(lo);
    num = (64'(v) - 64'(lo)) * (bip ? `SARM_SCALE_BI : `SARM_SCALE_UNI);
    q = (span == 64'sh0) ? 64'sh0 : num / span;
    if (bip) begin
      q = q - `SARM_SCALE_UNI;
    end
    floor = bip ? -`SARM_SCALE_UNI : 64'sh0;
    if (q > `SARM_SCALE_UNI) begin
      q = `SARM_SCALE_UNI;
    end
    if (q < floor) begin
      q = floor;
    end
    trackLevel = 32'(q);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command decode

  sarm_state_type state;
  sarm_state_type next_state;
  logic [1:0] beat;
  logic [1:0] beatLast;
  logic multiIdent;
  logic [2:0] multiSel;
  logic opcArmed;
  logic testFailed;
  logic [7:0] eventEnable;
  logic [7:0] svcEnable;
  logic [7:0] stickyStatus;
  sarm_alarm_cfg_type alarmCfg [`SARM_INPUTS];
  sarm_analog_cfg_type analogCfg [`SARM_OUTPUTS];

  wire take = cmdValid && cmdReady;
  wire doClear = isOp(take, cmd.op, OP_CLEAR_STATUS);
  wire doReset = isOp(take, cmd.op, OP_RESET);
  wire doEvtRead = isOp(take, cmd.op, OP_EVT_RD);
  wire doAlarmWr = isOp(take, cmd.op, OP_ALARM_WR);
  wire doAnalogWr = isOp(take, cmd.op, OP_ANALOG_WR);
  wire doLatchClr = isOp(take, cmd.op, OP_LATCHED_ALARM_CLEAR_CMD);
  wire knownOp = cmd.op <= OP_ANALOG_WR;
  wire anyAlarm = |{alarmHigh, alarmLow};
  wire opcDone = opcArmed && !opBusy;
  // completion answer waits while another command is taken, so two answers never meet
  wire opcAnswer = (state == ST_OPC_WAIT) && !opBusy && !take; // RL8

  ////////////////////////////////////////////////////////////////////////
  // event flags and status byte

  // an event arriving with a read or clear still lands: set wins
  wire [7:0] evtSet = {2'b00, take && !knownOp, events.execErr, events.devErr,
                       events.queryErr, 1'b0, opcDone}; // RL4 RL7
  wire [7:0] next_eventFlags = (eventFlags & ~{8{doClear | doEvtRead}}) | evtSet; // RL1
  wire [7:0] stickySet = {events.logDone, 2'b00, events.error, 1'b0, events.overload,
                          1'b0, events.newReading};
  wire [7:0] next_stickyStatus = (stickyStatus & ~{8{doClear}}) | stickySet; // RL1
  wire summaryBit = |(next_eventFlags & eventEnable); // RL13
  wire [7:0] statusBase = {next_stickyStatus[`SARM_STS_LOG], 1'b0, summaryBit,
                           next_stickyStatus[`SARM_STS_ERR], anyAlarm,
                           next_stickyStatus[`SARM_STS_OVL], 1'b0,
                           next_stickyStatus[`SARM_STS_NEW]}; // RL10
  // bit 6 masked so a request never feeds itself
  wire next_srq = |(statusBase & svcEnable & 8'hBF); // RL14
  wire [7:0] next_statusByte = statusBase | {1'b0, next_srq, 6'h00};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eventFlags <= `SARM_EVT_RESET;
      stickyStatus <= 8'h00;
      statusByte <= 8'h00;
      serviceRequest <= 1'b0;
    end else begin
      eventFlags <= next_eventFlags;
      stickyStatus <= next_stickyStatus;
      statusByte <= next_statusByte;
      serviceRequest <= next_srq;
    end
  end

  // enables and operation-complete arming survive the reset command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eventEnable <= `SARM_ENABLE_RESET;
      svcEnable <= `SARM_ENABLE_RESET;
      opcArmed <= 1'b0;
      testFailed <= 1'b0;
    end else begin
      if (isOp(take, cmd.op, OP_EVT_EN_WR)) begin
        eventEnable <= cmd.arg; // RL2 RL3
      end
      if (isOp(take, cmd.op, OP_SVC_EN_WR)) begin
        svcEnable <= cmd.arg; // RL12
      end
      if (doClear || opcDone) begin
        opcArmed <= 1'b0; // RL1
      end else if (isOp(take, cmd.op, OP_OPC)) begin
        opcArmed <= 1'b1; // RL7
      end
      if (selfTestDone) begin
        testFailed <= selfTestFail; // RL15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer sequencer

  sarm_rsp_type next_rsp;
  logic next_rspValid;
  logic [1:0] next_beat;
  logic [1:0] next_beatLast;
  logic next_multiIdent;
  logic [2:0] next_multiSel;

  always_comb begin
    next_state = state;
    next_rsp = rsp;
    next_rspValid = 1'b0;
    next_beat = beat;
    next_beatLast = beatLast;
    next_multiIdent = multiIdent;
    next_multiSel = multiSel;
    case (state)
      ST_IDLE, ST_OPC_WAIT: begin
        if (state == ST_OPC_WAIT && doClear) begin
          next_state = ST_IDLE; // RL1
        end else if (opcAnswer) begin
          next_state = ST_IDLE;
          next_rspValid = 1'b1;
          next_rsp = '{field: 2'h0, last: 1'b1, value: 32'h00000001}; // RL8
        end
        if (take) begin
          next_rsp = '{field: 2'h0, last: 1'b1, value: 32'h00000000};
          case (cmd.op)
            OP_EVT_EN_RD: begin
              next_rspValid = 1'b1;
              next_rsp.value = {24'h000000, eventEnable}; // RL5
            end
            OP_EVT_RD: begin
              next_rspValid = 1'b1;
              next_rsp.value = {24'h000000, eventFlags};
            end
            OP_SVC_EN_RD: begin
              next_rspValid = 1'b1;
              next_rsp.value = {24'h000000, svcEnable}; // RL12
            end
            OP_STATUS_RD: begin
              next_rspValid = 1'b1;
              next_rsp.value = {24'h000000, statusByte}; // RL11
            end
            OP_TEST_RD: begin
              next_rspValid = 1'b1;
              next_rsp.value = {31'h00000000, testFailed}; // RL15
            end
            OP_BEEPER_RD: begin
              next_rspValid = 1'b1;
              next_rsp.value = {31'h00000000, beeperOn}; // RL22
            end
            OP_IDENT_RD: begin
              next_rspValid = 1'b1;
              next_rsp.last = 1'b0;
              next_rsp.value = MAKER_CODE; // RL6
              next_state = ST_MULTI;
              next_beat = 2'h1;
              next_beatLast = `SARM_IDN_BEATS;
              next_multiIdent = 1'b1;
            end
            OP_ALARM_STATE_QUERY: begin
              next_rspValid = 1'b1;
              next_rsp.last = 1'b0;
              next_rsp.value = {31'h00000000, alarmHigh[cmd.sel]}; // RL21
              next_state = ST_MULTI;
              next_beat = 2'h1;
              next_beatLast = `SARM_ALST_BEATS;
              next_multiIdent = 1'b0;
              next_multiSel = cmd.sel;
            end
            OP_OPC_RD: begin
              next_state = ST_OPC_WAIT; // RL8
            end
            OP_CLEAR_STATUS: begin
              next_state = ST_IDLE;
            end
            default: begin
              next_rsp = rsp;
            end
          endcase
        end
      end
      ST_MULTI: begin
        next_rspValid = 1'b1;
        next_rsp.field = beat;
        next_rsp.last = (beat == beatLast);
        if (multiIdent) begin
          case (beat)
            2'h1: next_rsp.value = MODEL_CODE;
            2'h2: next_rsp.value = SERIAL_CODE;
            default: next_rsp.value = FIRMWARE_DATE;
          endcase
        end else begin
          next_rsp.value = {31'h00000000, alarmLow[multiSel]}; // RL21
        end
        next_beat = 2'(beat + 2'h1);
        if (beat == beatLast) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ready stays low until the last beat of a multi-beat answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cmdReady <= 1'b1;
      rspValid <= 1'b0;
      rsp <= '0;
      beat <= 2'h0;
      beatLast <= 2'h0;
      multiIdent <= 1'b0;
      multiSel <= 3'h0;
    end else begin
      state <= next_state;
      cmdReady <= (next_state != ST_MULTI);
      rspValid <= next_rspValid;
      rsp <= next_rsp;
      beat <= next_beat;
      beatLast <= next_beatLast;
      multiIdent <= next_multiIdent;
      multiSel <= next_multiSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarms and beeper

  // beep output runs one cycle behind the alarm state
  wire next_beeper = isOp(take, cmd.op, OP_BEEPER_CMD) ? cmd.arg[0] : beeperOn; // RL22

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beeperOn <= `SARM_BEEPER_RESET;
      beepOut <= 1'b0;
    end else begin
      beeperOn <= doReset ? `SARM_BEEPER_RESET : next_beeper; // RL9
      beepOut <= beeperOn && anyAlarm;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SARM_INPUTS; gi++) begin : g_alarm
      sarm_alarm_cfg_type c;
      assign c = alarmCfg[gi];
      wire sarm_value_type val = pickSource(readings, 4'(gi + 1), c.source);
      wire overHigh = val > c.high; // RL17
      wire underLow = val < c.low; // RL18
      // latched alarms skip the deadband and wait for the clear command
      wire releaseHigh = !c.latch && (val < c.high - c.band); // RL17 RL19
      wire releaseLow = !c.latch && (val > c.low + c.band); // RL18 RL19
      wire clearHigh = doLatchClr && c.latch && !overHigh; // RL20
      wire clearLow = doLatchClr && c.latch && !underLow; // RL20
      wire next_high = c.check && (overHigh || (alarmHigh[gi] && !releaseHigh && !clearHigh));
      wire next_low = c.check && (underLow || (alarmLow[gi] && !releaseLow && !clearLow));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          alarmCfg[gi] <= '{check: 1'b0, source: `SARM_SRC_FIRST, default: '0};
          alarmHigh[gi] <= 1'b0;
          alarmLow[gi] <= 1'b0;
        end else begin
          if (doReset) begin
            alarmCfg[gi] <= '{check: 1'b0, source: `SARM_SRC_FIRST, default: '0}; // RL9
          end else if (doAlarmWr && cmd.sel == 3'(gi)) begin
            alarmCfg[gi] <= cmd.alarm; // RL16
          end
          alarmHigh[gi] <= next_high;
          alarmLow[gi] <= next_low;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // analog outputs, level in thousandths of a percent

  genvar go;
  generate
    for (go = 0; go < `SARM_OUTPUTS; go++) begin : g_analog
      sarm_analog_cfg_type a;
      assign a = analogCfg[go];
      wire sarm_value_type mon = pickSource(readings, a.inputSel, a.source);
      wire sarm_value_type tracked = trackLevel(mon, a.low, a.high, a.bipolar); // RL24
      // level follows a new setting one cycle after it is written
      wire sarm_value_type next_level = (a.mode == `SARM_MODE_TRACK) ? tracked :
                                        (a.mode == `SARM_MODE_MANUAL) ? a.manual : 32'sh0; // RL25
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          analogCfg[go] <= '{mode: `SARM_MODE_OFF, inputSel: 4'h1, source: `SARM_SRC_FIRST,
                              default: '0};
          analogLevel[go] <= 32'sh0;
        end else begin
          if (doReset) begin
            analogCfg[go] <= '{mode: `SARM_MODE_OFF, inputSel: 4'h1, source: `SARM_SRC_FIRST,
                                default: '0}; // RL9
          end else if (doAnalogWr && cmd.sel == 3'(go)) begin
            analogCfg[go] <= cmd.analog; // RL23
          end
          analogLevel[go] <= next_level;
        end
      end
    end
  endgenerate

endmodule

// ===== testbench/sarm_unit_props.sv
// port checker for the status and alarm command unit
`timescale 1ns/100ps
`include "sarm_cfg.svh"

module sarm_unit_props import sarm_pkg::*; #(
  parameter logic [31:0] MAKER_CODE = 32'h00000A01,   // arbitrary value
  parameter logic [31:0] MODEL_CODE = 32'h00000B02,   // arbitrary value
  parameter logic [31:0] SERIAL_CODE = 32'h00000C03,  // arbitrary value
  parameter logic [31:0] FIRMWARE_DATE = 32'h00000D04 // arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire sarm_cmd_type cmd,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire sarm_rsp_type rsp,
  input wire sarm_event_type events,
  input wire logic [7:0] alarmHigh,
  input wire logic [7:0] alarmLow,
  input wire logic beeperOn,
  input wire logic beepOut,
  input wire logic [7:0] eventFlags,
  input wire logic [7:0] statusByte,
  input wire logic serviceRequest
);
  wire logic take = cmdValid && cmdReady;
  wire logic beepCond = beeperOn && (|(alarmHigh | alarmLow));
  // copies of the two enable registers, rebuilt from the accepted commands
  logic [7:0] sreShadow;
  logic [7:0] eseShadow;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sreShadow <= `SARM_ENABLE_RESET;
      eseShadow <= `SARM_ENABLE_RESET;
    end else begin
      if (take && cmd.op == OP_SVC_EN_WR) begin
        sreShadow <= cmd.arg;
      end
      if (take && cmd.op == OP_EVT_EN_WR) begin
        eseShadow <= cmd.arg;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  chk_srq_follows: assert property (
    serviceRequest == statusByte[`SARM_STS_SRQ] && serviceRequest == |(statusByte & $past(sreShadow) & 8'hBF))
    else $error("service request differs from status bit");
  chk_summary_bit: assert property (statusByte[`SARM_STS_ESB] == |(eventFlags & $past(eseShadow)))
    else $error("summary bit differs from enabled flags");
  chk_enable_answer: assert property (take && cmd.op == OP_EVT_EN_RD |=> rspValid && rsp.last)
    else $error("enable query answer missing");
  chk_ident_beats: assert property (
    take && cmd.op == OP_IDENT_RD |=> rspValid && rsp.field == 2'h0 && rsp.value == MAKER_CODE
    ##1 rspValid && rsp.value == MODEL_CODE ##1 rsp.value == SERIAL_CODE
    ##1 rspValid && rsp.last && rsp.value == FIRMWARE_DATE)
    else $error("identity beats wrong");
  chk_state_pair: assert property (
    take && cmd.op == OP_ALARM_STATE_QUERY |=> rspValid && !rsp.last && rsp.field == 2'h0
    ##1 rspValid && rsp.last && rsp.field == 2'h1)
    else $error("alarm state beats wrong");
  chk_busy_ready: assert property (rspValid && !rsp.last |-> !cmdReady)
    else $error("ready during multi beat answer");
  chk_beep_out: assert property (beepOut == $past(beepCond))
    else $error("beep output wrong");
  chk_opc_wait: assert property (
    take && cmd.op == OP_OPC_RD |=> !rspValid ##[1:1000] rspValid && rsp.value == 32'h00000001)
    else $error("completion answer wrong");
  chk_power_flag: assert property ($rose(nrst) |-> eventFlags == `SARM_EVT_RESET)
    else $error("power on flag missing");
  chk_alarm_bit: assert property ($rose(|alarmHigh) |-> ##[1:2] statusByte[`SARM_STS_ALM])
    else $error("alarm status bit missing");
  chk_exe_flag: assert property (events.execErr |=> eventFlags[`SARM_EVT_EXE])
    else $error("execution flag missing");
  chk_cme_flag: assert property (take && cmd.op > OP_ANALOG_WR |=> eventFlags[`SARM_EVT_CME])
    else $error("command error flag missing");
  cover property (take && cmd.op == OP_IDENT_RD);
  cover property ($rose(serviceRequest));
  cover property ($rose(beepOut));
endmodule

bind sarm_unit sarm_unit_props #(.MAKER_CODE(MAKER_CODE), .MODEL_CODE(MODEL_CODE),
  .SERIAL_CODE(SERIAL_CODE), .FIRMWARE_DATE(FIRMWARE_DATE)) props_u (.clk, .nrst, .cmdValid,
  .cmd, .cmdReady, .rspValid, .rsp, .events, .alarmHigh, .alarmLow, .beeperOn, .beepOut,
  .eventFlags, .statusByte, .serviceRequest);

// ===== testbench/sarm_host_model.sv
// host side command master: holds each command until taken
`timescale 1ns/100ps

module sarm_host_model import sarm_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqGo,
  input wire sarm_cmd_type reqCmd,
  input wire logic cmdReady,
  output logic cmdValid,
  output sarm_cmd_type cmd,
  output logic reqDone
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmdValid <= 1'b0;
      cmd <= '0;
      reqDone <= 1'b0;
    end else begin
      reqDone <= cmdValid && cmdReady;
      if (reqGo) begin
        cmdValid <= 1'b1;
        cmd <= reqCmd;
      end else if (!cmdValid || cmdReady) begin
        cmdValid <= 1'b0;
        // released lines keep changing
        cmd <= ~cmd;
      end
    end
  end
endmodule

// ===== testbench/test_sarm_unit.sv
// self-checking bench for the status and alarm command unit
`timescale 1ns/100ps
`include "sarm_cfg.svh"

module test_sarm_unit import sarm_pkg::*;;
  // arbitrary identity values
  localparam logic [31:0] IDS [4] = '{32'h0000A1A1, 32'h0000B2B2, 32'h0000C3C3, 32'h0000D4D4};
  logic clk = 1'b0, nrst = 1'b0, reqGo = 1'b0, opBusy = 1'b0, selfTestDone = 1'b0, selfTestFail = 1'b0;
  logic reqDone, cmdValid, cmdReady, rspValid, beeperOn, beepOut, srq;
  sarm_cmd_type c = '0, reqCmd = '0, cmd;
  sarm_rsp_type rsp, e;
  sarm_event_type events = '0;
  sarm_bank_type readings = '0;
  logic [7:0] alarmHigh, alarmLow, eventFlags, statusByte, a;
  sarm_value_type [1:0] analogLevel;
  int errTotal = 0, checks = 0, s;
  sarm_rsp_type q[$];
  int rv [10] = '{32'h50910, 32'h4E200, 32'h4DE18, 32'h3CCA8, 32'h3D284, 32'h3D66C, 32'h50910, 32'h0,
    32'h493E0, 32'h0};
  logic [9:0] eh = 10'h1C3, el = 10'h018;
  sarm_value_type ar [5] = '{32'h186A0, 32'h0, 32'h0, 32'hC350, 32'h50910};
  sarm_value_type ax [5] = '{32'h186A0, 32'h0, 32'hFFFE7960, 32'h0, 32'h3039};

  sarm_host_model host_u (.clk, .nrst, .reqGo, .reqCmd, .cmdReady, .cmdValid, .cmd, .reqDone);
  sarm_unit #(.MAKER_CODE(IDS[0]), .MODEL_CODE(IDS[1]), .SERIAL_CODE(IDS[2]), .FIRMWARE_DATE(IDS[3]))
    dut_u (.clk, .nrst, .cmdValid, .cmd, .cmdReady, .rspValid, .rsp, .events, .opBusy, .selfTestDone,
    .selfTestFail, .readings, .alarmHigh, .alarmLow, .beeperOn, .beepOut, .analogLevel, .eventFlags,
    .statusByte, .serviceRequest(srq));
  ////////////////////////////////////////////////////////////
  task results();
    if (errTotal == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [34:0] seen, input logic [34:0] want);
    checks++;
    if (seen !== want) begin
      errTotal++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task exp(input logic [1:0] f, input logic l, input logic [31:0] v);
    q.push_back('{f, l, v});
  endtask
  task go(input sarm_op_type o);
    int n;
    n = 0;
    c.op = o;
    reqCmd <= c;
    reqGo <= 1'b1;
    @(posedge clk);
    reqGo <= 1'b0;
    while (reqDone !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk(0, 1);
  endtask
  task ask(input sarm_op_type o, input logic [31:0] v);
    exp(2'h0, 1'b1, v);
    go(o);
  endtask
  task wr(input sarm_op_type o, input logic [7:0] v);
    c.arg = v;
    go(o);
  endtask
  ////////////////////////////////////////////////////////////
  initial forever #4 clk = ~clk;
  initial begin
    #400000;
    errTotal++;
    results();
  end
  // answer monitor
  always @(posedge clk) begin
    if (rspValid === 1'b1) begin
      if (q.size() == 0) chk(0, 1);
      else begin
        e = q.pop_front();
        chk(rsp, e);
      end
    end
  end
  initial begin
    void'($urandom(80));
    tick(20);
    nrst <= 1'b1;
    tick(2);
    chk(eventFlags, 8'h80);
    chk(statusByte, 8'h00);
    ask(OP_EVT_RD, 8'h80);
    ask(OP_EVT_RD, 8'h00);
    a = $urandom & 8'hFF;
    wr(OP_EVT_EN_WR, a);
    ask(OP_EVT_EN_RD, a);
    wr(OP_SVC_EN_WR, 8'h59);
    ask(OP_SVC_EN_RD, 8'h59);
    for (int i = 0; i < 4; i++) exp(2'(i), i == 3, IDS[i]);
    go(OP_IDENT_RD);
    for (int f = 1; f >= 0; f--) begin
      selfTestFail <= f[0];
      selfTestDone <= 1'b1;
      @(posedge clk);
      selfTestDone <= 1'b0;
      ask(OP_TEST_RD, f);
    end
    go(sarm_op_type'(5'h1F));
    ask(OP_EVT_RD, 8'h20);
    for (int k = 0; k < 3; k++) begin
      events <= sarm_event_type'(7'h01 << k);
      @(posedge clk);
      events <= '0;
      ask(OP_EVT_RD, 8'h10 >> k);
    end
    wr(OP_EVT_EN_WR, 8'h10);
    events <= sarm_event_type'(7'h79);
    @(posedge clk);
    events <= '0;
    tick(3);
    chk(statusByte, 8'hF5);
    ask(OP_STATUS_RD, 8'hF5);
    ask(OP_STATUS_RD, 8'hF5);
    go(OP_CLEAR_STATUS);
    tick(3);
    chk({eventFlags, statusByte}, 16'h0000);
    wr(OP_SVC_EN_WR, 8'h20);
    events <= sarm_event_type'(7'h01);
    @(posedge clk);
    events <= '0;
    tick(3);
    chk({srq, statusByte}, 9'h160);
    ask(OP_EVT_RD, 8'h10);
    tick(3);
    chk(statusByte, 8'h00);
    wr(OP_BEEPER_CMD, 8'h01);
    ask(OP_BEEPER_RD, 1);
    s = $urandom_range(7);
    c.sel = 3'(s);
    readings <= {32{32'h493E0}};
    c.alarm = '{1'b1, 3'h1, 32'h4E3F4, 32'h3D090, 32'h3E8, 1'b0};
    go(OP_ALARM_WR);
    for (int i = 0; i < 10; i++) begin
      if (i == 6) begin
        c.alarm.latch = 1'b1;
        go(OP_ALARM_WR);
      end
      if (rv[i] == 0) go(OP_LATCHED_ALARM_CLEAR_CMD);
      else readings <= {32{rv[i]}};
      tick(3);
      chk(alarmHigh, eh[i] ? 8'h01 << s : 8'h00);
      chk(alarmLow, el[i] ? 8'h01 << s : 8'h00);
      if (i == 3 || i == 8) begin
        exp(2'h0, 1'b0, eh[i]);
        exp(2'h1, 1'b1, el[i]);
        go(OP_ALARM_STATE_QUERY);
      end
    end
    wr(OP_BEEPER_CMD, 8'h00);
    ask(OP_BEEPER_RD, 0);
    wr(OP_BEEPER_CMD, 8'h01);
    c.sel = 3'h0;
    for (int i = 0; i < 5; i++) begin
      c.analog = '{i > 1, i == 4 ? `SARM_MODE_MANUAL : `SARM_MODE_TRACK, 4'h3, 3'h2, 32'h186A0, 32'h0, 32'h3039};
      // only input 3, source 2 carries the value, so a wrong pick reads zero
      readings <= {992'h0, ar[i]} << 288;
      go(OP_ANALOG_WR);
      tick(3);
      chk(analogLevel[0], ax[i]);
      chk(analogLevel[1], 32'h0);
    end
    go(OP_RESET);
    tick(3);
    chk({alarmLow, analogLevel[0]}, 40'h0);
    ask(OP_BEEPER_RD, 0);
    opBusy <= 1'b1;
    go(OP_OPC);
    tick(3);
    chk(eventFlags[0], 1'b0);
    opBusy <= 1'b0;
    tick(3);
    chk(eventFlags, 8'h01);
    opBusy <= 1'b1;
    exp(2'h0, 1'b1, 1);
    go(OP_OPC_RD);
    tick(5);
    opBusy <= 1'b0;
    tick(4);
    chk(q.size(), 0);
    results();
  end
endmodule
